//--- hdl/jdsp_map.svh
// Offsets, field positions, instruction codes, chain selectors and response codes of the debug and scan port.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef JDSP_MAP_SVH
`define JDSP_MAP_SVH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define JDSP_OFS_CTRL 8'h00
`define JDSP_OFS_STAT 8'h04
`define JDSP_OFS_CHIPID 8'h08
`define JDSP_OFS_COMM_TX 8'h0c
`define JDSP_OFS_COMM_RX 8'h10
`define JDSP_OFS_INJECT 8'h14
// ****************************************
// Field positions
// ****************************************
`define JDSP_CTRL_BLOCK 0
`define JDSP_STAT_SCAN 0
`define JDSP_STAT_TX 1
`define JDSP_STAT_RX 2
`define JDSP_STAT_HALT 3
`define JDSP_STAT_FTEST 4
// ****************************************
// Instruction codes and chain lengths
// ****************************************
`define JDSP_IR_EXTEST 4'h0
`define JDSP_IR_SAMPLE 4'h1
`define JDSP_IR_SCAN_N 4'h2
`define JDSP_IR_INTEST 4'hc
`define JDSP_IR_IDCODE 4'he
`define JDSP_IR_BYPASS 4'hf
`define JDSP_IR_CAPTURE 4'h1
`define JDSP_BS_LEN 187
`define JDSP_BS_PINS 62
`define JDSP_PAD_IN 63
`define JDSP_CHAIN_INJ 2'h0
`define JDSP_CHAIN_COMM 2'h1
`define JDSP_CHAIN_CTL 2'h2
`define JDSP_RESP_OK 2'h0
`define JDSP_RESP_ERR 2'h2
`endif

//--- hdl/jdsp_pkg.sv
// Types shared by the debug and scan port modules.
// Assumes jdsp_map.svh is on the include path.
`default_nettype none
package jdsp_pkg;
  // Sixteen-state test access port controller
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } jdsp_tap_t;

  // Whole state of the top module
  typedef struct packed {
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    logic [1:0] sel_s;
    logic [1:0] ftest_s;
    logic mode_scan;
    jdsp_tap_t tap;
    logic [3:0] ir;
    logic [3:0] ir_sh;
    logic [31:0] dr;
    logic [1:0] chain;
    logic tdo;
    logic tdo_oe;
    logic halt;
    logic inj_v;
    logic [31:0] inj_instr;
    logic rx_full;
    logic [31:0] rx_data;
    logic tx_full;
    logic [31:0] tx_data;
    logic block;
    logic aw_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } jdsp_st_t;
endpackage : jdsp_pkg
`default_nettype wire

//--- hdl/jdsp_bscan_cells.sv
// Boundary cell chain: three cells per two-way pin plus one input-only cell.
// Assumes strobes come from the port controller on the same aclk.
`timescale 1ns/1ps
`default_nettype none
`include "jdsp_map.svh"
module jdsp_bscan_cells (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic extest,
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  input wire logic tdi,
  output logic tdo_bit,
  input wire logic [`JDSP_PAD_IN-1:0] pad_in,
  input wire logic [`JDSP_BS_PINS-1:0] core_out,
  input wire logic [`JDSP_BS_PINS-1:0] core_oe,
  output logic [`JDSP_BS_PINS-1:0] pad_out,
  output logic [`JDSP_BS_PINS-1:0] pad_oe,
  output logic [`JDSP_PAD_IN-1:0] core_in
);
  typedef struct packed {
    logic [`JDSP_PAD_IN-1:0] s1;
    logic [`JDSP_PAD_IN-1:0] s2;
    logic [`JDSP_BS_LEN-1:0] sh;
    logic [`JDSP_BS_LEN-1:0] upd;
    logic [`JDSP_BS_PINS-1:0] po;
    logic [`JDSP_BS_PINS-1:0] poe;
  } jdsp_bs_t;
  jdsp_bs_t st_ff;
  jdsp_bs_t nxt_st;
  logic [`JDSP_BS_LEN-1:0] cap;
  logic [`JDSP_BS_PINS-1:0] drv_o;
  logic [`JDSP_BS_PINS-1:0] drv_e;

  // ****************************************
  // Cell triples per pin
  // ****************************************
  genvar i;
  for (i = 0; i < `JDSP_BS_PINS; i++) begin : g_pin
    assign cap[3*i] = core_oe[i]; // RULE8
    assign cap[3*i+1] = core_out[i];
    assign cap[3*i+2] = st_ff.s2[i]; // RULE10
    assign drv_o[i] = extest ? st_ff.upd[3*i+1] : core_out[i]; // RULE9
    assign drv_e[i] = extest ? st_ff.upd[3*i] : core_oe[i]; // RULE11
  end
  assign cap[`JDSP_BS_LEN-1] = st_ff.s2[`JDSP_PAD_IN-1];

  // Capture, shift LSB first, update; pad side registered
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = pad_in;
    nxt_st.s2 = st_ff.s1;
    if (capture) begin
      nxt_st.sh = cap;
    end else if (shift) begin
      nxt_st.sh = {tdi, st_ff.sh[`JDSP_BS_LEN-1:1]}; // RULE7
    end
    if (update) begin
      nxt_st.upd = st_ff.sh;
    end
    nxt_st.po = drv_o;
    nxt_st.poe = drv_e;
    if (!aresetn) begin
      nxt_st.sh = '0;
      nxt_st.upd = '0;
      nxt_st.po = '0;
      nxt_st.poe = '0;
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  assign tdo_bit = st_ff.sh[0];
  assign pad_out = st_ff.po;
  assign pad_oe = st_ff.poe;
  assign core_in = st_ff.s2;

  property p_extest_drive;
    @(posedge aclk) disable iff (!aresetn)
    extest |=> (pad_oe[0] == $past(st_ff.upd[0])) && (pad_out[0] == $past(st_ff.upd[1]));
  endproperty
  a_extest_drive: assert property (p_extest_drive) else $error("pad not driven from cells"); // RULE9
endmodule : jdsp_bscan_cells
`default_nettype wire

//--- hdl/jdsp_port.sv
// Debug and scan port top: test access port sampled on aclk, debug chains,
// boundary cells and an AXI4-Lite slave for the processor side.
// Assumes tck, tms, tdi, selects and pads are asynchronous to aclk.
//
// Contract
// RULE1: Factory test pin held low by board
// RULE2: Select low gives emulation debug mode
// RULE3: Select high gives boundary scan mode
// RULE4: Mode changes only through chip reset
// RULE5: Scan mode offers SAMPLE, EXTEST, BYPASS
// RULE6: Debug mode identifies with processor-specific code
// RULE7: Boundary chain is 187 bits long
// RULE8: Each two-way pin has three cells
// RULE9: Output cell drives pad under EXTEST
// RULE10: Input cell captures the pad level
// RULE11: Control cell sets pad direction
// RULE12: Halt mode injects store-multiple instruction
// RULE13: Monitor data flows both ways
// RULE14: Three internal chains selected via port
// RULE15: Channel activity flags feed processor interrupts
// RULE16: Software can block emulation access
// RULE17: Read-only 32-bit chip identity
// RULE18: Select sampled during reset, then held
// RULE19: Standard controller sequencing, LSB first
`timescale 1ns/1ps
`default_nettype none
`include "jdsp_map.svh"
module jdsp_port #(
  parameter logic [31:0] CHIP_ID = 32'h0000_0a01, // Arbitrary value
  parameter logic [31:0] PROC_ID = 32'h0000_0b01 // Arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic debug_or_scan_select,
  input wire logic factory_test_pin,
  output logic scan_mode,
  output logic halt_req,
  output logic store_multiple_injection,
  output logic [31:0] inject_instr,
  output logic comm_channel_tx_activity,
  output logic comm_channel_rx_activity,
  input wire logic [`JDSP_PAD_IN-1:0] pad_in,
  output logic [`JDSP_BS_PINS-1:0] pad_out,
  output logic [`JDSP_BS_PINS-1:0] pad_oe,
  input wire logic [`JDSP_BS_PINS-1:0] core_out,
  input wire logic [`JDSP_BS_PINS-1:0] core_oe,
  output logic [`JDSP_PAD_IN-1:0] core_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  jdsp_pkg::jdsp_st_t st_ff;
  jdsp_pkg::jdsp_st_t nxt_st;
  logic rise;
  logic fall;
  logic bs_sel;
  logic dbg_ok;
  logic bs_tdo;

  // ****************************************
  // Controller sequencing
  // ****************************************
  function automatic jdsp_pkg::jdsp_tap_t tap_next(input jdsp_pkg::jdsp_tap_t t,
                                                  input logic m);
    case (t)
      jdsp_pkg::TLR: tap_next = m ? jdsp_pkg::TLR : jdsp_pkg::RTI;
      jdsp_pkg::RTI: tap_next = m ? jdsp_pkg::SEL_DR : jdsp_pkg::RTI;
      jdsp_pkg::SEL_DR: tap_next = m ? jdsp_pkg::SEL_IR : jdsp_pkg::CAP_DR;
      jdsp_pkg::CAP_DR: tap_next = m ? jdsp_pkg::EX1_DR : jdsp_pkg::SH_DR;
      jdsp_pkg::SH_DR: tap_next = m ? jdsp_pkg::EX1_DR : jdsp_pkg::SH_DR;
      jdsp_pkg::EX1_DR: tap_next = m ? jdsp_pkg::UPD_DR : jdsp_pkg::PAU_DR;
      jdsp_pkg::PAU_DR: tap_next = m ? jdsp_pkg::EX2_DR : jdsp_pkg::PAU_DR;
      jdsp_pkg::EX2_DR: tap_next = m ? jdsp_pkg::UPD_DR : jdsp_pkg::SH_DR;
      jdsp_pkg::UPD_DR: tap_next = m ? jdsp_pkg::SEL_DR : jdsp_pkg::RTI;
      jdsp_pkg::SEL_IR: tap_next = m ? jdsp_pkg::TLR : jdsp_pkg::CAP_IR;
      jdsp_pkg::CAP_IR: tap_next = m ? jdsp_pkg::EX1_IR : jdsp_pkg::SH_IR;
      jdsp_pkg::SH_IR: tap_next = m ? jdsp_pkg::EX1_IR : jdsp_pkg::SH_IR;
      jdsp_pkg::EX1_IR: tap_next = m ? jdsp_pkg::UPD_IR : jdsp_pkg::PAU_IR;
      jdsp_pkg::PAU_IR: tap_next = m ? jdsp_pkg::EX2_IR : jdsp_pkg::PAU_IR;
      jdsp_pkg::EX2_IR: tap_next = m ? jdsp_pkg::UPD_IR : jdsp_pkg::SH_IR;
      jdsp_pkg::UPD_IR: tap_next = m ? jdsp_pkg::SEL_DR : jdsp_pkg::RTI;
      default: tap_next = jdsp_pkg::TLR;
    endcase
  endfunction : tap_next

  // Edges of the test clock from the synchronised copy
  assign rise = st_ff.tck_s[1] & ~st_ff.tck_s[2];
  assign fall = ~st_ff.tck_s[1] & st_ff.tck_s[2];
  assign bs_sel = st_ff.mode_scan & ((st_ff.ir == `JDSP_IR_EXTEST) |
                  (st_ff.ir == `JDSP_IR_SAMPLE)); // RULE5
  assign dbg_ok = ~st_ff.mode_scan & ~st_ff.block; // RULE16

  // ****************************************
  // Boundary cells
  // ****************************************
  jdsp_bscan_cells u_cells (
    .aclk(aclk),
    .aresetn(aresetn),
    .extest(st_ff.mode_scan && st_ff.ir == `JDSP_IR_EXTEST),
    .capture(rise && bs_sel && st_ff.tap == jdsp_pkg::CAP_DR),
    .shift(rise && bs_sel && st_ff.tap == jdsp_pkg::SH_DR),
    .update(rise && bs_sel && st_ff.tap == jdsp_pkg::UPD_DR),
    .tdi(st_ff.tdi_s[1]),
    .tdo_bit(bs_tdo),
    .pad_in(pad_in),
    .core_out(core_out),
    .core_oe(core_oe),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .core_in(core_in)
  );

  // Next state: synchronisers, port controller, debug chains, bus slave, reset
  always_comb begin
    jdsp_pkg::jdsp_st_t r;
    logic [7:0] ra;
    r = '0;
    ra = s_axi_araddr;
    nxt_st = st_ff;
    nxt_st.tck_s = {st_ff.tck_s[1:0], tck};
    nxt_st.tms_s = {st_ff.tms_s[0], tms};
    nxt_st.tdi_s = {st_ff.tdi_s[0], tdi};
    nxt_st.sel_s = {st_ff.sel_s[0], debug_or_scan_select};
    nxt_st.ftest_s = {st_ff.ftest_s[0], factory_test_pin}; // RULE1
    nxt_st.inj_v = 1'b0;
    // Read channel; a read of the receive word frees it
    nxt_st.ar_rdy = s_axi_arvalid & ~st_ff.ar_rdy & ~st_ff.rvalid;
    if (st_ff.ar_rdy) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `JDSP_RESP_OK;
      case (ra)
        `JDSP_OFS_CTRL: nxt_st.rdata = {31'h0, st_ff.block};
        `JDSP_OFS_STAT: nxt_st.rdata = {27'h0, st_ff.ftest_s[1], st_ff.halt,
                                       st_ff.rx_full, st_ff.tx_full, st_ff.mode_scan};
        `JDSP_OFS_CHIPID: nxt_st.rdata = CHIP_ID; // RULE17
        `JDSP_OFS_COMM_TX: nxt_st.rdata = st_ff.tx_data;
        `JDSP_OFS_COMM_RX: begin
          nxt_st.rdata = st_ff.rx_data;
          nxt_st.rx_full = 1'b0;
        end
        `JDSP_OFS_INJECT: nxt_st.rdata = st_ff.inj_instr;
        default: begin
          nxt_st.rdata = 32'h0;
          nxt_st.rresp = `JDSP_RESP_ERR;
        end
      endcase
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // Port controller on each rising test clock edge
    if (rise) begin
      nxt_st.tap = tap_next(st_ff.tap, st_ff.tms_s[1]); // RULE19
      case (st_ff.tap)
        jdsp_pkg::TLR: nxt_st.ir = st_ff.mode_scan ? `JDSP_IR_BYPASS : `JDSP_IR_IDCODE;
        jdsp_pkg::CAP_IR: nxt_st.ir_sh = `JDSP_IR_CAPTURE;
        jdsp_pkg::SH_IR: nxt_st.ir_sh = {st_ff.tdi_s[1], st_ff.ir_sh[3:1]}; // RULE19
        jdsp_pkg::UPD_IR: nxt_st.ir = st_ff.ir_sh;
        jdsp_pkg::CAP_DR: begin
          nxt_st.dr = 32'h0;
          if (dbg_ok && st_ff.ir == `JDSP_IR_IDCODE) begin
            nxt_st.dr = PROC_ID; // RULE6
          end else if (dbg_ok && st_ff.ir == `JDSP_IR_INTEST) begin
            case (st_ff.chain)
              `JDSP_CHAIN_INJ: nxt_st.dr = st_ff.inj_instr;
              `JDSP_CHAIN_COMM: begin
                nxt_st.dr = st_ff.tx_data; // RULE13
                nxt_st.tx_full = 1'b0;
              end
              `JDSP_CHAIN_CTL: nxt_st.dr = {29'h0, st_ff.tx_full, st_ff.rx_full, st_ff.halt};
              default: nxt_st.dr = 32'h0;
            endcase
          end
        end
        jdsp_pkg::SH_DR: begin
          if (dbg_ok && (st_ff.ir == `JDSP_IR_IDCODE || st_ff.ir == `JDSP_IR_INTEST)) begin
            nxt_st.dr = {st_ff.tdi_s[1], st_ff.dr[31:1]};
          end else if (dbg_ok && st_ff.ir == `JDSP_IR_SCAN_N) begin
            nxt_st.dr = {28'h0, st_ff.tdi_s[1], st_ff.dr[3:1]};
          end else begin
            nxt_st.dr = {31'h0, st_ff.tdi_s[1]}; // RULE5
          end
        end
        jdsp_pkg::UPD_DR: begin
          if (dbg_ok && st_ff.ir == `JDSP_IR_SCAN_N) begin
            nxt_st.chain = st_ff.dr[1:0]; // RULE14
          end else if (dbg_ok && st_ff.ir == `JDSP_IR_INTEST) begin
            case (st_ff.chain)
              `JDSP_CHAIN_INJ: begin
                nxt_st.inj_instr = st_ff.dr;
                nxt_st.inj_v = st_ff.halt; // RULE12
              end
              `JDSP_CHAIN_COMM: begin
                nxt_st.rx_data = st_ff.dr;
                nxt_st.rx_full = 1'b1; // RULE15
              end
              `JDSP_CHAIN_CTL: nxt_st.halt = st_ff.dr[0]; // RULE14
              default: nxt_st.halt = st_ff.halt;
            endcase
          end
        end
        default: nxt_st.tap = tap_next(st_ff.tap, st_ff.tms_s[1]);
      endcase
    end
    // Output data changes on the falling test clock edge
    if (fall) begin
      nxt_st.tdo_oe = (st_ff.tap == jdsp_pkg::SH_IR) | (st_ff.tap == jdsp_pkg::SH_DR);
      if (st_ff.tap == jdsp_pkg::SH_IR) begin
        nxt_st.tdo = st_ff.ir_sh[0];
      end else if (st_ff.tap == jdsp_pkg::SH_DR) begin
        nxt_st.tdo = bs_sel ? bs_tdo : st_ff.dr[0];
      end
    end
    // Write channel; a write to the transmit word wins over a capture
    nxt_st.aw_rdy = s_axi_awvalid & s_axi_wvalid & ~st_ff.aw_rdy & ~st_ff.bvalid;
    if (st_ff.aw_rdy) begin
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `JDSP_RESP_OK;
      case (s_axi_awaddr)
        `JDSP_OFS_CTRL: begin
          if (s_axi_wstrb[0]) begin
            nxt_st.block = s_axi_wdata[`JDSP_CTRL_BLOCK]; // RULE16
          end
        end
        `JDSP_OFS_COMM_TX: begin
          for (int k = 0; k < 4; k++) begin
            if (s_axi_wstrb[k]) begin
              nxt_st.tx_data[8*k +: 8] = s_axi_wdata[8*k +: 8];
            end
          end
          nxt_st.tx_full = 1'b1; // RULE15
        end
        `JDSP_OFS_STAT, `JDSP_OFS_CHIPID, `JDSP_OFS_COMM_RX, `JDSP_OFS_INJECT: begin
          nxt_st.bresp = `JDSP_RESP_OK;
        end
        default: nxt_st.bresp = `JDSP_RESP_ERR;
      endcase
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // Synchronous reset; the select level is caught while reset is held
    if (!aresetn) begin
      r.tck_s = nxt_st.tck_s;
      r.tms_s = nxt_st.tms_s;
      r.tdi_s = nxt_st.tdi_s;
      r.sel_s = nxt_st.sel_s;
      r.ftest_s = nxt_st.ftest_s;
      r.mode_scan = st_ff.sel_s[1]; // RULE18
      r.ir = st_ff.sel_s[1] ? `JDSP_IR_BYPASS : `JDSP_IR_IDCODE; // RULE2 RULE3
      nxt_st = r;
    end
  end

  always_ff @(posedge aclk) begin
    st_ff <= nxt_st;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign tdo = st_ff.tdo;
  assign tdo_oe = st_ff.tdo_oe;
  assign scan_mode = st_ff.mode_scan;
  assign halt_req = st_ff.halt;
  assign store_multiple_injection = st_ff.inj_v;
  assign inject_instr = st_ff.inj_instr;
  assign comm_channel_tx_activity = st_ff.tx_full;
  assign comm_channel_rx_activity = st_ff.rx_full;
  assign s_axi_awready = st_ff.aw_rdy;
  assign s_axi_wready = st_ff.aw_rdy;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.ar_rdy;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rdata = st_ff.rdata;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_upd_dbg;
    rise && st_ff.tap == jdsp_pkg::UPD_DR && dbg_ok && st_ff.ir == `JDSP_IR_INTEST;
  endsequence
  property p_mode_hold;
    $past(aresetn) |-> $stable(st_ff.mode_scan);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved outside reset"); // RULE4
  property p_tlr_ir;
    rise && st_ff.tap == jdsp_pkg::TLR |=>
      st_ff.ir == (st_ff.mode_scan ? `JDSP_IR_BYPASS : `JDSP_IR_IDCODE);
  endproperty
  a_tlr_ir: assert property (p_tlr_ir) else $error("wrong instruction after reset"); // RULE2
  property p_idcode;
    rise && st_ff.tap == jdsp_pkg::CAP_DR && dbg_ok && st_ff.ir == `JDSP_IR_IDCODE
      |=> st_ff.dr == PROC_ID;
  endproperty
  a_idcode: assert property (p_idcode) else $error("identifier not captured"); // RULE6
  property p_tdo_oe;
    fall && st_ff.tap == jdsp_pkg::SH_DR |=> tdo_oe ##0 tdo == (bs_sel ? $past(bs_tdo)
      : $past(st_ff.dr[0]));
  endproperty
  a_tdo_oe: assert property (p_tdo_oe) else $error("shift data not presented"); // RULE19
  property p_halt_upd;
    s_upd_dbg ##0 st_ff.chain == `JDSP_CHAIN_CTL |=> halt_req == $past(st_ff.dr[0]);
  endproperty
  a_halt_upd: assert property (p_halt_upd) else $error("halt not loaded"); // RULE14
  property p_inject;
    store_multiple_injection |-> halt_req ##1 !store_multiple_injection;
  endproperty
  a_inject: assert property (p_inject) else $error("injection outside halt"); // RULE12
  property p_rx_set;
    s_upd_dbg ##0 st_ff.chain == `JDSP_CHAIN_COMM |=>
      comm_channel_rx_activity && st_ff.rx_data == $past(st_ff.dr);
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("receive activity not raised"); // RULE13
  property p_block;
    st_ff.block |=> $stable(st_ff.rx_data) && $stable(st_ff.halt);
  endproperty
  a_block: assert property (p_block) else $error("blocked access changed state"); // RULE16
  property p_chipid;
    s_axi_arready && s_axi_araddr == `JDSP_OFS_CHIPID |=> s_axi_rvalid && s_axi_rdata == CHIP_ID;
  endproperty
  a_chipid: assert property (p_chipid) else $error("chip identity wrong"); // RULE17
endmodule : jdsp_port
`default_nettype wire

//--- verification/jdsp_dbg_model.sv
// Debugger model: drives the four-wire test port with its own 160 ns clock.
// Assumes the bench calls one task at a time; the clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module jdsp_dbg_model (
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input wire logic tdo
);
  // ****************************************
  // Test clock frames
  // ****************************************
  // Idle levels at time zero
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One period: set lines while low, sample tdo just before the rise
  task automatic step(input logic md, input logic dv, output logic o);
    tms = md;
    tdi = dv;
    #80;
    o = tdo;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask : step
  // Five high mode bits reach reset from any state, then idle
  task automatic tap_reset();
    logic o;
    #7;
    for (int i = 0; i < 6; i++) begin
      step(i < 5, 1'b0, o);
    end
  endtask : tap_reset
  // Shift n bits LSB first through IR or DR, idle to idle; tdi then shows the inverse
  task automatic shift(input logic ir, input int n, input logic [191:0] din,
                       output logic [191:0] dout);
    logic o;
    dout = '0;
    #7;
    step(1'b1, ~din[0], o);
    if (ir) begin
      step(1'b1, ~din[0], o);
    end
    step(1'b0, ~din[0], o);
    step(1'b0, ~din[0], o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, ~din[n-1], o);
    step(1'b0, ~din[n-1], o);
    #40; // Let the update reach the pads before the bench looks
  endtask : shift
endmodule : jdsp_dbg_model
`default_nettype wire

//--- verification/jtag_debug_scan_port_tb.sv
// Bench for the debug and scan port: registers, debug chains and boundary scan.
// Assumes jdsp_map.svh on the include path and the debugger model compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "jdsp_map.svh"
module jtag_debug_scan_port_tb;
  localparam logic [31:0] CID = 32'h0000_0c11; // Arbitrary value
  localparam logic [31:0] PID = 32'h0000_0d22; // Arbitrary value
  localparam logic [61:0] OUTP = 62'h1234_5678_9abc_def0;
  localparam logic [61:0] OEP = 62'h0f0f_3c3c_a5a5_5a5a;
  localparam logic [61:0] CORE_OUT = 62'h2aaa_aaaa_5555_5555;
  localparam logic [61:0] CORE_OE = 62'h3333_cccc_0000_ffff;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [1:0] r;
  } jdsp_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic debug_or_scan_select = 1'b0;
  logic [62:0] pad_in = 63'h2a5a_f00f_1234_5678;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic tck, tms, tdi, tdo, scan_mode, halt_req, smi, ctx, crx, toe;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] inj, s_axi_rdata, d;
  logic [61:0] pad_out, pad_oe;
  logic [62:0] cin;
  logic [191:0] q, p, e, m;
  int num_errors = 0, total_checks = 0, cycles = 0, inj_pulses = 0;
  jdsp_row_t rows [7] = '{
    '{`JDSP_OFS_CHIPID, CID, `JDSP_RESP_OK},
    '{`JDSP_OFS_STAT, 32'h0, `JDSP_RESP_OK},
    '{`JDSP_OFS_CTRL, 32'h0, `JDSP_RESP_OK},
    '{`JDSP_OFS_INJECT, 32'h0, `JDSP_RESP_OK},
    '{`JDSP_OFS_COMM_RX, 32'h0, `JDSP_RESP_OK},
    '{`JDSP_OFS_COMM_TX, 32'h0, `JDSP_RESP_OK},
    '{8'h18, 32'h0, `JDSP_RESP_ERR}};
  jdsp_port #(.CHIP_ID(CID), .PROC_ID(PID)) i_dut (
    .aclk, .aresetn, .tck, .tms, .tdi, .tdo, .tdo_oe(toe), .debug_or_scan_select,
    .factory_test_pin(1'b0), .scan_mode, .halt_req, .store_multiple_injection(smi),
    .inject_instr(inj), .comm_channel_tx_activity(ctx), .comm_channel_rx_activity(crx),
    .pad_in, .pad_out, .pad_oe, .core_out(CORE_OUT), .core_oe(CORE_OE), .core_in(cin),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  jdsp_dbg_model i_dbg (.tck, .tms, .tdi, .tdo);
  // ****************************************
  // Clock, watchdog and shared tasks
  // ****************************************
  // 50 MHz system clock
  always #10 aclk = ~aclk;
  // Watchdog and injection pulse counter, sampled mid-cycle
  always @(negedge aclk) begin
    cycles++;
    inj_pulses += (smi === 1'b1);
    if (cycles == 30000) begin
      num_errors++;
      end_of_test();
    end
  end
  // Compare and count
  task automatic chk(input logic [191:0] got, input logic [191:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Register write; response code left in r
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(negedge aclk);
  endtask : axi_wr
  // Register read; data in d, response code in r
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(negedge aclk);
  endtask : axi_rd
  // Select a debug chain, then exchange one 32-bit word with it
  task automatic chain_xfer(input logic [1:0] c, input logic [31:0] w);
    i_dbg.shift(1'b1, 4, `JDSP_IR_SCAN_N, q);
    i_dbg.shift(1'b0, 4, c, q);
    i_dbg.shift(1'b1, 4, `JDSP_IR_INTEST, q);
    i_dbg.shift(1'b0, 32, w, q);
  endtask : chain_xfer
  // Counts, verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // ****************************************
  // Main sequence
  // ****************************************
  // Debug mode first, then a second reset into boundary scan mode
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_wr(`JDSP_OFS_CHIPID, 32'hffff_ffff);
    chk(r, `JDSP_RESP_OK);
    axi_wr(8'h1c, 32'h1);
    chk(r, `JDSP_RESP_ERR);
    foreach (rows[i]) begin
      axi_rd(rows[i].a);
      chk({r, d}, {rows[i].r, rows[i].d});
    end
    chk(scan_mode, 1'b0);
    i_dbg.tap_reset();
    i_dbg.shift(1'b1, 4, `JDSP_IR_IDCODE, q);
    chk(q[3:0], `JDSP_IR_CAPTURE);
    i_dbg.shift(1'b0, 32, 192'h0, q);
    chk(q[31:0], PID);
    axi_wr(`JDSP_OFS_COMM_TX, 32'h1357_9bdf);
    chk(ctx, 1'b1);
    chain_xfer(`JDSP_CHAIN_COMM, 32'h2468_ace0);
    chk(q[31:0], 32'h1357_9bdf);
    chk({ctx, crx}, 2'b01);
    axi_rd(`JDSP_OFS_COMM_RX);
    chk({crx, d}, {1'b0, 32'h2468_ace0});
    chain_xfer(`JDSP_CHAIN_INJ, 32'h0bad_0001);
    chk(inj_pulses, 0);
    chain_xfer(`JDSP_CHAIN_CTL, 32'h1);
    chk({halt_req, q[2:0]}, 4'h8);
    chain_xfer(`JDSP_CHAIN_INJ, 32'hcafe_0123);
    chk({inj_pulses[1:0], inj}, {2'd1, 32'hcafe_0123});
    axi_rd(`JDSP_OFS_INJECT);
    chk(d, 32'hcafe_0123);
    axi_wr(`JDSP_OFS_CTRL, 32'h1);
    i_dbg.shift(1'b0, 33, 33'h1_2345_6789, q);
    chk(q[32:0], {32'h2345_6789, 1'b0});
    @(posedge aclk);
    debug_or_scan_select <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(scan_mode, 1'b0);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`JDSP_OFS_STAT);
    chk({scan_mode, d}, {1'b1, 32'h1});
    chk({pad_oe, pad_out}, {CORE_OE, CORE_OUT});
    p = '0;
    e = '0;
    m = '0;
    for (int i = 0; i < 62; i++) begin
      p[3*i] = OEP[i];
      p[3*i+1] = OUTP[i];
      m[3*i+2] = 1'b1;
      e[3*i+2] = pad_in[i];
    end
    m[186] = 1'b1;
    e[186] = pad_in[62];
    i_dbg.tap_reset();
    i_dbg.shift(1'b1, 4, `JDSP_IR_EXTEST, q);
    i_dbg.shift(1'b0, 187, p, q);
    chk(q & m, e);
    chk({pad_oe, pad_out}, {OEP, OUTP});
    chk({toe, cin}, {1'b0, pad_in});
    m[187] = 1'b1;
    e[187] = p[0];
    i_dbg.shift(1'b1, 4, `JDSP_IR_SAMPLE, q);
    i_dbg.shift(1'b0, 188, p, q);
    chk(q & m, e);
    i_dbg.shift(1'b1, 4, `JDSP_IR_BYPASS, q);
    i_dbg.shift(1'b0, 8, 8'hb5, q);
    chk({q[7:0], pad_oe, pad_out}, {8'h6a, CORE_OE, CORE_OUT});
    end_of_test();
  end
endmodule : jtag_debug_scan_port_tb
`default_nettype wire
